// ### inc/tmr_pkg.sv
package tmr_pkg;
    // register byte offsets
    localparam logic [11:0] CONFIG_OFS = 12'h000;
    localparam logic [11:0] COUNT_OFS = 12'h004;
    localparam logic [11:0] UPTIME_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00c;
    localparam logic [11:0] MASK_OFS = 12'h010;

    // field positions
    localparam int PRELOAD_LSB = 0;
    localparam int PRELOAD_MSB = 15;
    localparam int ENABLE_BIT = 16;
    localparam int TICK_FLAG_BIT = 0;

    // reset, wrap and zero values
    localparam logic [15:0] PRELOAD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'hffff;
    localparam logic [15:0] COUNT_WRAP = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [31:0] UPTIME_RESET = 32'h0000_0000;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
    localparam int TICK_NS = 100_000;
    localparam int TICK_CYCLES = (TICK_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_NS / CLK_PERIOD_NS;
    localparam int UPTIME_MHZ = 25;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_RD_FETCH,
        BUS_RD_DONE
    } bus_state_t;
endpackage : tmr_pkg

// ### design/periodic_timer_core.sv
module periodic_timer_core #(
    parameter int TICK_CYCLES = tmr_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic [15:0] count_reg,
    output logic wrap_reg
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    logic [15:0] prescale_reg;
    logic tick;

    // prescaler restarts on every load so the first period is whole
    assign tick = run && !load && (prescale_reg == TICK_LAST); // R1 R17

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_reg <= 16'h0000;
        end else if (load || !run || prescale_reg == TICK_LAST) begin
            prescale_reg <= 16'h0000; // R17
        end else begin
            prescale_reg <= prescale_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= tmr_pkg::COUNT_RESET; // R4
        end else if (load) begin
            count_reg <= load_value; // R2 R6
        end else if (tick) begin
            if (count_reg == tmr_pkg::COUNT_ZERO) begin
                count_reg <= tmr_pkg::COUNT_WRAP; // R7
            end else begin
                count_reg <= count_reg - 16'h0001; // R1 R6
            end
        end
    end

    // disabled: no tick, so count holds and no event
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wrap_reg <= 1'b0;
        end else begin
            wrap_reg <= tick && (count_reg == tmr_pkg::COUNT_ZERO); // R8 R18
        end
    end
endmodule : periodic_timer_core

// ### design/uptime_counter_core.sv
module uptime_counter_core #(
    parameter int UPTIME_MHZ = tmr_pkg::UPTIME_MHZ,
    parameter int CLK_MHZ = tmr_pkg::CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    output logic [31:0] value_reg
);
    // the 25 MHz count is kept exact by a phase accumulator on clk_sys:
    // value always equals whole 25 MHz periods elapsed, at the cost of
    // stepping by more than one per clk_sys edge
    logic [7:0] phase_reg;
    logic [7:0] phase_sum;
    logic [7:0] step;

    function automatic logic [7:0] whole_steps(input logic [7:0] sum);
        whole_steps = 8'(int'(sum) / CLK_MHZ);
    endfunction : whole_steps

    assign phase_sum = phase_reg + 8'(UPTIME_MHZ);
    assign step = whole_steps(phase_sum);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= 8'h00;
        end else begin
            phase_reg <= phase_sum - 8'(int'(step) * CLK_MHZ);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            value_reg <= tmr_pkg::UPTIME_RESET; // R12 R16
        end else begin
            value_reg <= value_reg + {24'h000000, step}; // R11 R13 R14
        end
    end
endmodule : uptime_counter_core

// ### design/periodic_timer_and_uptime_counter.sv
// Behaviour
// R1 - 16-bit timer count decrements once every 100 us.
// R2 - setting timer enable copies the preload into the count.
// R3 - reset or enable falling sets preload to ffff.
// R4 - reset sets the timer count to ffff.
// R5 - preload may be written whether enabled or not.
// R6 - enabled timer counts down; a new preload restarts the count.
// R7 - at zero the count wraps to ffff and keeps counting.
// R8 - each zero reached sets the periodic tick flag.
// R9 - the interrupt is raised only if the tick irq enable is set.
// R10 - tick flag is sticky; write one clears, write zero does nothing.
// R11 - 32-bit up-counter at 25 MHz readable in its own register.
// R12 - reset clears the uptime counter.
// R13 - after reset the uptime counter advances once per 25 MHz period.
// R14 - uptime counter rolls over to zero and continues.
// R15 - uptime counter never raises an interrupt or flag.
// R16 - uptime counter is zero within 160 ns of reset.
// R17 - 100 us tick from a prescaler, reset whenever the count loads.
// R18 - while disabled the count holds and no flag is set.
//
// The AHB-Lite register port and the register offsets were decided locally.
module periodic_timer_and_uptime_counter #(
    parameter int TICK_CYCLES = tmr_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq
);
    tmr_pkg::bus_state_t bus_state_reg;
    tmr_pkg::bus_state_t bus_state_next;
    logic accept;
    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [11:0] rd_addr_reg;
    logic [31:0] hrdata_reg;

    logic enable_reg;
    logic [15:0] preload_reg;
    logic status_reg;
    logic mask_reg;

    logic cfg_wr;
    logic status_wr;
    logic mask_wr;
    logic new_enable;
    logic [15:0] new_preload;
    logic timer_load;
    logic [15:0] count_value;
    logic timer_wrap;
    logic [31:0] uptime_value;

    // hsize is not checked: only whole-word transfers are expected
    assign accept = hsel && hready && htrans[1];

    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic en,
        input logic [15:0] pre,
        input logic [15:0] cnt,
        input logic [31:0] up,
        input logic st,
        input logic mk
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        if (addr == tmr_pkg::CONFIG_OFS) begin
            word[tmr_pkg::ENABLE_BIT] = en;
            word[tmr_pkg::PRELOAD_MSB:tmr_pkg::PRELOAD_LSB] = pre;
        end else if (addr == tmr_pkg::COUNT_OFS) begin
            word[15:0] = cnt;
        end else if (addr == tmr_pkg::UPTIME_OFS) begin
            word = up; // R11
        end else if (addr == tmr_pkg::STATUS_OFS) begin
            word[tmr_pkg::TICK_FLAG_BIT] = st;
        end else if (addr == tmr_pkg::MASK_OFS) begin
            word[tmr_pkg::TICK_FLAG_BIT] = mk;
        end
        read_word = word;
    endfunction : read_word

    // reads take one wait state so a write just before is already visible
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            tmr_pkg::BUS_IDLE, tmr_pkg::BUS_RD_DONE: begin
                if (accept && !hwrite) begin
                    bus_state_next = tmr_pkg::BUS_RD_FETCH;
                end else begin
                    bus_state_next = tmr_pkg::BUS_IDLE;
                end
            end
            tmr_pkg::BUS_RD_FETCH: begin
                bus_state_next = tmr_pkg::BUS_RD_DONE;
            end
            default: begin
                bus_state_next = tmr_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state_reg <= tmr_pkg::BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            rd_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= accept && hwrite;
            if (accept) begin
                wr_addr_reg <= haddr[11:0];
                rd_addr_reg <= haddr[11:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (bus_state_reg == tmr_pkg::BUS_RD_FETCH) begin
            hrdata_reg <= read_word(rd_addr_reg, enable_reg, preload_reg, count_value,
                                    uptime_value, status_reg, mask_reg);
        end
    end

    assign hreadyout = (bus_state_reg != tmr_pkg::BUS_RD_FETCH);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // upper address bits are ignored, so the map repeats every 4 KiB
    assign cfg_wr = wr_pend_reg && (wr_addr_reg == tmr_pkg::CONFIG_OFS);
    assign status_wr = wr_pend_reg && (wr_addr_reg == tmr_pkg::STATUS_OFS);
    assign mask_wr = wr_pend_reg && (wr_addr_reg == tmr_pkg::MASK_OFS);
    assign new_enable = hwdata[tmr_pkg::ENABLE_BIT];
    assign new_preload = hwdata[tmr_pkg::PRELOAD_MSB:tmr_pkg::PRELOAD_LSB];

    // any config write with enable set (re)loads the count
    assign timer_load = cfg_wr && new_enable; // R2 R6

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
        end else if (cfg_wr) begin
            enable_reg <= new_enable;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            preload_reg <= tmr_pkg::PRELOAD_RESET; // R3
        end else if (cfg_wr) begin
            if (enable_reg && !new_enable) begin
                preload_reg <= tmr_pkg::PRELOAD_RESET; // R3
            end else begin
                preload_reg <= new_preload; // R5
            end
        end
    end

    periodic_timer_core #(
        .TICK_CYCLES(TICK_CYCLES)
    ) timer_core (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(enable_reg),
        .load(timer_load),
        .load_value(new_preload),
        .count_reg(count_value),
        .wrap_reg(timer_wrap)
    );

    uptime_counter_core #(
        .UPTIME_MHZ(tmr_pkg::UPTIME_MHZ),
        .CLK_MHZ(tmr_pkg::CLK_MHZ)
    ) uptime_core (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .value_reg(uptime_value)
    );

    // a wrap in the same cycle as a clearing write keeps the flag set
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status_reg <= 1'b0;
        end else begin
            status_reg <= (status_reg && !(status_wr && hwdata[tmr_pkg::TICK_FLAG_BIT]))
                          || timer_wrap; // R8 R10
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= 1'b0;
        end else if (mask_wr) begin
            mask_reg <= hwdata[tmr_pkg::TICK_FLAG_BIT];
        end
    end

    // uptime has no path into status or irq
    assign irq = status_reg && mask_reg; // R9 R15
endmodule : periodic_timer_and_uptime_counter

// ### tb/periodic_timer_and_uptime_counter_assertions.sv
module periodic_timer_and_uptime_counter_assertions #(
    parameter int TICK_CYCLES = tmr_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic ph_wr, ph_rd, mask_q;
    logic [11:0] ph_a;
    wire logic take = hsel && hready && htrans[1];
    wire logic unmapped = ph_a[1:0] != 2'h0 || ph_a > tmr_pkg::MASK_OFS;
    // only a status clear or a mask drop may lower the interrupt
    wire logic clr = ph_wr && hready && ((ph_a == tmr_pkg::STATUS_OFS && hwdata[0])
        || (ph_a == tmr_pkg::MASK_OFS && !hwdata[0]));
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_a <= 12'h000;
            mask_q <= 1'b0;
        end else begin
            if (hready) begin
                ph_wr <= take && hwrite;
                ph_rd <= take && !hwrite;
                ph_a <= haddr[11:0];
            end
            if (ph_wr && hready && ph_a == tmr_pkg::MASK_OFS)
                mask_q <= hwdata[0];
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_ready_idle: assert property (!ph_rd |-> hreadyout)
        else $error("stall outside read");
    a_rdata_hold: assert property (!(ph_rd && !hreadyout) |=> $stable(hrdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (ph_rd && hreadyout && unmapped |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (irq |-> mask_q)
        else $error("irq while masked");
    a_irq_sticky: assert property ($fell(irq) |-> $past(clr))
        else $error("irq dropped without clear");
endmodule : periodic_timer_and_uptime_counter_assertions

bind periodic_timer_and_uptime_counter periodic_timer_and_uptime_counter_assertions #(
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .irq);

// ### tb/tb_periodic_timer_and_uptime_counter.sv
module tb_periodic_timer_and_uptime_counter;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 4;
    logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, wr_ph = 1'b0, rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, q0, m_rd, d;
    logic [15:0] rnd = 16'hee8e, m_pre, m_cnt;
    logic [11:0] ph_a = 12'h000, a;
    logic [11:0] tbl [5] = '{tmr_pkg::CONFIG_OFS, tmr_pkg::COUNT_OFS, tmr_pkg::STATUS_OFS,
        tmr_pkg::MASK_OFS, 12'h014};
    logic m_en, m_st, m_mk, m_wrap;
    int m_ps, mismatches = 0, checked = 0;
    wire logic hreadyout, hresp, irq;
    wire logic [31:0] hrdata;
    periodic_timer_and_uptime_counter #(.TICK_CYCLES(TC)) u_dut (.clk_sys, .sys_rst, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .irq);
    initial forever #50 clk_sys = ~clk_sys;
    task automatic results();
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic [31:0] expf(input logic [11:0] o);
        case (o)
            tmr_pkg::CONFIG_OFS: return {15'h0, m_en, m_pre};
            tmr_pkg::COUNT_OFS: return {16'h0, m_cnt};
            tmr_pkg::STATUS_OFS: return {31'h0, m_st};
            tmr_pkg::MASK_OFS: return {31'h0, m_mk};
            default: return 32'h0;
        endcase
    endfunction : expf
    task automatic bus(input logic w, input logic [11:0] o, input logic [31:0] wd,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, o};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wr_ph <= w;
        rd_ph <= !w;
        ph_a <= o;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
        wr_ph <= 1'b0;
        rd_ph <= 1'b0;
    endtask : bus
    task automatic rc(input logic [11:0] o);
        logic [31:0] r;
        bus(1'b0, o, 32'h0, r);
        chk(r, m_rd);
    endtask : rc
    // model sees pre-edge values, as the registers do
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            m_en = 1'b0;
            m_pre = 16'hffff;
            m_cnt = 16'hffff;
            m_ps = 0;
            m_st = 1'b0;
            m_mk = 1'b0;
            m_wrap = 1'b0;
        end else begin
            if (rd_ph && !hreadyout) m_rd = expf(ph_a);
            if (wr_ph && ph_a == tmr_pkg::STATUS_OFS && hwdata[0]) m_st = 1'b0;
            if (m_wrap) m_st = 1'b1;
            m_wrap = 1'b0;
            if (m_en) m_ps = m_ps + 1;
            if (m_ps == TC) begin
                m_ps = 0;
                m_wrap = m_cnt == 16'h0000;
                m_cnt = m_cnt - 16'h0001;
            end
            if (wr_ph && ph_a == tmr_pkg::MASK_OFS) m_mk = hwdata[0];
            if (wr_ph && ph_a == tmr_pkg::CONFIG_OFS) begin
                m_pre = hwdata[16] ? hwdata[15:0] : (m_en ? 16'hffff : hwdata[15:0]);
                if (hwdata[16]) m_cnt = hwdata[15:0];
                // a reload on the tick edge suppresses that tick, so no wrap event
                if (hwdata[16]) m_wrap = 1'b0;
                m_en = hwdata[16];
                m_ps = 0;
            end
        end
    end
    always @(negedge clk_sys) if (!sys_rst) chk({31'h0, irq}, {31'h0, m_st & m_mk});
    initial begin
        #2000000;
        mismatches++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        bus(1'b0, tmr_pkg::UPTIME_OFS, 32'h0, q0);
        chk({31'h0, q0 < 32'h10}, 32'h1);
        for (int i = 0; i < 5; i++) rc(tbl[i]);
        bus(1'b0, tmr_pkg::UPTIME_OFS, 32'h0, q0);
        bus(1'b0, tmr_pkg::UPTIME_OFS, 32'h0, q);
        bus(1'b0, tmr_pkg::UPTIME_OFS, 32'h0, q);
        // two reads six cycles apart at 2.5 counts per cycle
        chk(q - q0, 32'h0000000f);
        for (int i = 0; i < 400; i++) begin
            rnd = lfsr(rnd);
            a = tbl[rnd % 5];
            // short preloads so wraps occur between config writes
            d = (a == tmr_pkg::CONFIG_OFS) ? {15'h0, rnd[6], 14'h0, rnd[9:8]} : {rnd, rnd};
            repeat (rnd[15:13]) @(posedge clk_sys);
            if (rnd[3]) bus(1'b1, a, d, q);
            else rc(a);
        end
        results();
    end
endmodule : tb_periodic_timer_and_uptime_counter
